// *** rtl/rtc_trim_alarm_watchdog_irq.sv ***
`timescale 1ns/1ps

// Behaviour
// (RQ1) Trim magnitude is unsigned five low bits.
// (RQ2) Trim bit five chooses faster or slower.
// (RQ3) Sixty-four minute cycle, one second adjusted.
// (RQ4) Magnitude N adjusts first 2N minutes.
// (RQ5) Test bit toggles interrupt at 512 Hz.
// (RQ6) Host freezes before changing test bit.
// (RQ7) Alarm match sets flag, optional interrupt.
// (RQ8) Per-field masks; all masked disables alarm.
// (RQ9) Alarm values take effect after freeze clears.
// (RQ10) Host keeps seconds mask at zero.
// (RQ11) Watchdog counts 32 Hz ticks from oscillator.
// (RQ12) Watchdog loads at reset; kick reloads.
// (RQ13) Reaching zero sets timeout flag, optional interrupt.
// (RQ14) Lock bit blocks timeout value writes.
// (RQ15) Zero timeout value disables the watchdog.
// (RQ16) Supply drop sets flag, optional interrupt.
// (RQ17) No interrupts while on backup supply.
// (RQ18) Interrupt needs a set flag with enable.
// (RQ19) Polarity bit selects push-pull high or open-drain low.
// (RQ20) Pulse mode about 200 ms, else level.
// (RQ21) Flags read clears flags and interrupt.
// (RQ22) Flags reset to zero except oscillator failure.
// (RQ23) Alarm compared on each seconds update.
module rtc_trim_alarm_watchdog_irq
	import rtc_trim_pkg::*;
#(
	parameter int unsigned PULSE_CYCLES = PULSE_DEF
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic        i_osc_clk,
	input  wire logic        i_vcc_low,
	input  wire logic        i_on_backup,
	input  wire logic        i_osc_fail,
	input  wire logic        i_sel,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [14:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_sec_update,
	input  wire time_type    i_now,
	output logic      [7:0]  o_rdata,
	output logic             o_sec_tick,
	output logic             o_osc_disable,
	output logic             o_irq_out,
	output logic             o_irq_oe
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [3:0] meta_reg;
	logic [3:0] sync_reg;
	logic       osc_prev_reg;
	wire  [3:0] async_in = {i_osc_clk, i_vcc_low, i_on_backup, i_osc_fail};
	wire        osc_s    = sync_reg[3];
	wire        low_s    = sync_reg[2];
	wire        backup_s = sync_reg[1];
	wire        fail_s   = sync_reg[0];

	always_ff @(posedge i_mclk) begin
		meta_reg     <= async_in;
		sync_reg     <= meta_reg;
		osc_prev_reg <= osc_s;
	end

	// ****************************************************************
	// Register decode
	// ****************************************************************
	logic [7:0] flags_reg;
	logic [7:0] irq_ctl_reg;
	logic [7:0] trim_reg;
	logic [5:0] wd_val_reg;
	logic       wd_lock_reg;

	wire wr_en    = i_sel & i_wr;
	wire rd_en    = i_sel & i_rd;
	wire wr_flags = wr_en & (i_addr == ADDR_FLAGS);
	wire wr_irq   = wr_en & (i_addr == ADDR_IRQ);
	wire wr_to    = wr_en & (i_addr == ADDR_TIMEOUT);
	wire wr_trim  = wr_en & (i_addr == ADDR_TRIM);
	wire rd_flags = rd_en & (i_addr == ADDR_FLAGS);
	wire freeze   = flags_reg[FLG_FREEZE];
	wire [14:0] alm_off = i_addr - ADDR_ALM_BASE;
	wire alm_hit  = (i_addr >= ADDR_ALM_BASE) && (alm_off < 15'(ALM_FIELDS));

	// Stopping the oscillator also stops every count that hangs off it.
	// (RQ11) oscillator edge enable
	wire osc_tick = osc_s & ~osc_prev_reg & ~trim_reg[TRIM_OSCOFF];

	// ****************************************************************
	// Raw prescaler: test tone and watchdog tick
	// ****************************************************************
	logic [9:0] raw_cnt_reg;
	logic       test_reg;
	// (RQ5) untrimmed test tone
	wire test_edge = osc_tick && ((raw_cnt_reg & TEST_HALF_M1) == TEST_HALF_M1);
	// (RQ11) 32 Hz tick
	wire wd_tick   = osc_tick && (raw_cnt_reg == WD_DIV_M1);

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			raw_cnt_reg <= '0;
			test_reg    <= 1'b0;
		end else if (osc_tick) begin
			raw_cnt_reg <= raw_cnt_reg + 10'h001;
			test_reg    <= test_reg ^ test_edge;
		end
	end

	// ****************************************************************
	// Trimmed seconds divider
	// ****************************************************************
	logic [16:0] sec_cnt_reg;
	logic [5:0]  sec_idx_reg;
	logic [5:0]  min_idx_reg;
	logic        sec_tick_reg;
	// (RQ1) unsigned magnitude
	wire  [5:0]  trim_span = {trim_reg[4:0], 1'b0};
	// (RQ3) (RQ4) adjusted second
	wire         trim_now  = (sec_idx_reg == 6'h00) && (min_idx_reg < trim_span)
	                         && (min_idx_reg < TRIM_MIN_LAST);
	// (RQ2) sign selects direction
	wire  [16:0] sec_len   = !trim_now ? SEC_NOM : (trim_reg[TRIM_SIGN] ? SEC_SHORT : SEC_LONG);
	wire         sec_done  = osc_tick && (sec_cnt_reg == sec_len - 17'h00001);

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			sec_cnt_reg  <= '0;
			sec_idx_reg  <= '0;
			min_idx_reg  <= '0;
			sec_tick_reg <= 1'b0;
		end else begin
			sec_tick_reg <= sec_done;
			if (sec_done) begin
				sec_cnt_reg <= '0;
				sec_idx_reg <= (sec_idx_reg == SECS_LAST) ? 6'h00 : sec_idx_reg + 6'h01;
				if (sec_idx_reg == SECS_LAST)
					min_idx_reg <= min_idx_reg + 6'h01;
			end else if (osc_tick) begin
				sec_cnt_reg <= sec_cnt_reg + 17'h00001;
			end
		end
	end

	// ****************************************************************
	// Alarm
	// ****************************************************************
	logic       freeze_prev_reg;
	logic [7:0] alm_wr_reg  [ALM_FIELDS];
	logic [7:0] alm_act_reg [ALM_FIELDS];
	wire  [7:0] now_f       [ALM_FIELDS];
	logic [ALM_FIELDS-1:0] field_ok;
	logic [ALM_FIELDS-1:0] field_mask;
	// (RQ9) values commit when freeze clears
	wire        alm_commit = freeze_prev_reg & ~freeze;

	assign now_f[0] = i_now.seconds;
	assign now_f[1] = i_now.minutes;
	assign now_f[2] = i_now.hours;
	assign now_f[3] = i_now.date;

	genvar gi;
	generate
		for (gi = 0; gi < ALM_FIELDS; gi++) begin : g_alm
			wire wr_this = wr_en && alm_hit && freeze && (alm_off[1:0] == 2'(gi));
			// (RQ8) masked or equal
			assign field_mask[gi] = alm_act_reg[gi][ALM_MASK];
			assign field_ok[gi]   = field_mask[gi]
			                        || (alm_act_reg[gi][6:0] == now_f[gi][6:0]);
			always_ff @(posedge i_mclk) begin
				if (!i_rstn) begin
					alm_wr_reg[gi]  <= ALM_RESET;
					alm_act_reg[gi] <= ALM_RESET;
				end else begin
					if (wr_this)
						alm_wr_reg[gi] <= i_wdata;
					if (alm_commit)
						alm_act_reg[gi] <= alm_wr_reg[gi];
				end
			end
		end
	endgenerate

	// (RQ7) (RQ23) compare on seconds update; (RQ10) seconds mask assumed 0
	wire alarm_hit = i_sec_update && (&field_ok) && !(&field_mask);

	// ****************************************************************
	// Watchdog
	// ****************************************************************
	logic [5:0] wd_cnt_reg;
	wire  [5:0] wd_new    = (wr_to && !i_wdata[TO_LOCK]) ? i_wdata[5:0] : wd_val_reg;
	wire        wd_kick   = wr_to && i_wdata[TO_KICK];
	// (RQ13) (RQ15) expiry only from a live count
	wire        wd_expire = wd_tick && !wd_kick && (wd_cnt_reg == 6'h01) && (wd_val_reg != 6'h00);

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			wd_val_reg  <= WD_RESET;
			wd_cnt_reg  <= WD_RESET;
			wd_lock_reg <= 1'b0;
		end else begin
			if (wr_to)
				wd_lock_reg <= i_wdata[TO_LOCK];
			// (RQ14) lock guards the value
			wd_val_reg <= wd_new;
			// (RQ12) kick reloads the count
			if (wd_kick)
				wd_cnt_reg <= wd_new;
			else if (wd_tick && wd_cnt_reg != 6'h00)
				wd_cnt_reg <= wd_cnt_reg - 6'h01;
		end
	end

	// ****************************************************************
	// Flags and control registers
	// ****************************************************************
	logic       low_prev_reg;
	logic       init_reg;
	// (RQ16) supply drop event
	wire        supply_fall = low_s & ~low_prev_reg;
	wire  [2:0] events      = {wd_expire, alarm_hit, supply_fall};
	// (RQ21) read clears, a same-cycle event still lands
	wire  [2:0] ev_next     = (flags_reg[7:5] & {3{~rd_flags}}) | events;
	wire        cal_next    = (wr_flags && freeze) ? i_wdata[FLG_CAL] : flags_reg[FLG_CAL];
	wire        oscillator_failure_bit_clr    = wr_flags && freeze && !i_wdata[FLG_OSCILLATOR_FAILURE_BIT];

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			// (RQ22) flags start at zero
			flags_reg    <= FLAGS_RESET;
			irq_ctl_reg  <= IRQ_RESET;
			trim_reg     <= TRIM_RESET;
			low_prev_reg <= 1'b0;
			init_reg     <= 1'b0;
			freeze_prev_reg <= 1'b0;
		end else begin
			low_prev_reg            <= low_s;
			init_reg                <= 1'b1;
			freeze_prev_reg         <= freeze;
			flags_reg[7:5]          <= ev_next;
			flags_reg[FLG_CAL]      <= cal_next;
			// The failure bit is caught once after release, then only cleared.
			if (!init_reg)
				flags_reg[FLG_OSCILLATOR_FAILURE_BIT] <= fail_s;
			else if (oscillator_failure_bit_clr)
				flags_reg[FLG_OSCILLATOR_FAILURE_BIT] <= 1'b0;
			if (wr_flags) begin
				flags_reg[FLG_FREEZE] <= i_wdata[FLG_FREEZE];
				flags_reg[FLG_READ]   <= i_wdata[FLG_READ];
			end
			if (wr_irq)
				irq_ctl_reg <= i_wdata & IRQ_WMASK;
			if (wr_trim)
				trim_reg <= i_wdata & TRIM_WMASK;
		end
	end

	// ****************************************************************
	// Interrupt driver
	// ****************************************************************
	logic        pulse_reg;
	logic [31:0] pulse_cnt_reg;
	logic        req_prev_reg;
	logic        act_reg;
	logic        irq_out_reg;
	logic        irq_oe_reg;
	// (RQ18) (RQ17) flag with enable, main power only
	wire  [2:0]  irq_en   = {irq_ctl_reg[IRQ_TO_EN], irq_ctl_reg[IRQ_AL_EN], irq_ctl_reg[IRQ_SL_EN]};
	wire         irq_req  = (|(flags_reg[7:5] & irq_en)) && !backup_s;
	wire         test_on  = flags_reg[FLG_CAL];
	wire         pulse_on = irq_ctl_reg[IRQ_PULSE];
	wire         high_on  = irq_ctl_reg[IRQ_HIGH];
	// (RQ20) pulse or level
	wire         act_next = !backup_s && (test_on ? test_reg : (pulse_on ? pulse_reg : irq_req));
	// (RQ19) push-pull high above threshold, else open drain low
	wire         out_next = high_on ? (act_next && !low_s) : 1'b0;
	wire         oe_next  = high_on ? !backup_s : act_next;

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			pulse_reg     <= 1'b0;
			pulse_cnt_reg <= '0;
			req_prev_reg  <= 1'b0;
			act_reg       <= 1'b0;
			irq_out_reg   <= 1'b0;
			irq_oe_reg    <= 1'b0;
		end else begin
			req_prev_reg <= irq_req;
			act_reg      <= act_next;
			irq_out_reg  <= out_next;
			irq_oe_reg   <= oe_next;
			// (RQ21) a read cuts the pulse short
			if (rd_flags) begin
				pulse_reg     <= 1'b0;
				pulse_cnt_reg <= '0;
			end else if (irq_req && !req_prev_reg) begin
				pulse_reg     <= 1'b1;
				pulse_cnt_reg <= 32'(PULSE_CYCLES - 1);
			end else if (pulse_cnt_reg != 0) begin
				pulse_cnt_reg <= pulse_cnt_reg - 32'h00000001;
			end else begin
				pulse_reg <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	logic [7:0] rdata_reg;
	wire  [7:0] rd_mux = (i_addr == ADDR_FLAGS)   ? flags_reg :
	                     alm_hit                  ? alm_wr_reg[alm_off[1:0]] :
	                     (i_addr == ADDR_IRQ)     ? irq_ctl_reg :
	                     (i_addr == ADDR_TIMEOUT) ? {1'b0, wd_lock_reg, wd_val_reg} :
	                     (i_addr == ADDR_TRIM)    ? trim_reg : RD_NONE;

	always_ff @(posedge i_mclk) begin
		if (!i_rstn)
			rdata_reg <= RD_NONE;
		else if (rd_en)
			rdata_reg <= rd_mux;
	end

	assign o_rdata       = rdata_reg;
	assign o_sec_tick    = sec_tick_reg;
	assign o_osc_disable = trim_reg[TRIM_OSCOFF];
	assign o_irq_out     = irq_out_reg;
	assign o_irq_oe      = irq_oe_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	sequence kick_s;
		wr_to && i_wdata[TO_KICK] && !i_wdata[TO_LOCK];
	endsequence

	flag_clear_a: assert property (rd_flags && events == 3'b000 |=> flags_reg[7:5] == 3'b000) // (RQ21)
		else $error("flags not cleared by read");
	pulse_cut_a: assert property (rd_flags && events == 3'b000 |=> !pulse_reg ##1 !act_reg || test_on) // (RQ21)
		else $error("pulse survived flags read");
	timeout_set_a: assert property (wd_expire |=> flags_reg[FLG_TIMEOUT]) // (RQ13)
		else $error("timeout flag missing");
	wdog_off_a: assert property (wd_val_reg == 6'h00 && !wr_to |-> !wd_expire) // (RQ15)
		else $error("disabled watchdog expired");
	value_lock_a: assert property (wr_to && i_wdata[TO_LOCK] |=> $stable(wd_val_reg)) // (RQ14)
		else $error("locked timeout value changed");
	kick_load_a: assert property (kick_s |=> wd_cnt_reg == $past(i_wdata[5:0])) // (RQ12)
		else $error("kick did not reload count");
	alarm_commit_a: assert property (alm_commit |=> alm_act_reg[0] == $past(alm_wr_reg[0])) // (RQ9)
		else $error("alarm value not committed");
	alarm_off_a: assert property (&field_mask && !flags_reg[FLG_MATCH] |=> !flags_reg[FLG_MATCH]) // (RQ8)
		else $error("masked alarm fired");
	irq_gate_a: assert property (!test_on && !irq_req && !pulse_reg |=> !act_reg) // (RQ18)
		else $error("interrupt without enabled flag");
	backup_quiet_a: assert property (backup_s |=> !act_reg) // (RQ17)
		else $error("interrupt on backup supply");
	pulse_hold_a: assert property (pulse_reg && pulse_cnt_reg > 1 && !rd_flags |=> pulse_reg) // (RQ20)
		else $error("pulse ended early");
	trim_short_a: assert property (sec_done && trim_now && trim_reg[TRIM_SIGN]
		|-> sec_cnt_reg == SEC_SHORT - 17'h00001) // (RQ3)
		else $error("shortened second length wrong");

endmodule

// *** rtl/rtc_trim_pkg.sv ***
package rtc_trim_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [14:0] ADDR_FLAGS    = 15'h7ff0;
	localparam logic [14:0] ADDR_ALM_BASE = 15'h7ff2;
	localparam logic [14:0] ADDR_IRQ      = 15'h7ff6;
	localparam logic [14:0] ADDR_TIMEOUT  = 15'h7ff7;
	localparam logic [14:0] ADDR_TRIM     = 15'h7ff8;
	localparam int          ALM_FIELDS    = 4;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int FLG_TIMEOUT = 7;
	localparam int FLG_MATCH   = 6;
	localparam int FLG_SUPPLY  = 5;
	localparam int FLG_OSCILLATOR_FAILURE_BIT    = 4;
	localparam int FLG_CAL     = 2;
	localparam int FLG_FREEZE  = 1;
	localparam int FLG_READ    = 0;
	localparam int IRQ_TO_EN   = 7;
	localparam int IRQ_AL_EN   = 6;
	localparam int IRQ_SL_EN   = 5;
	localparam int IRQ_HIGH    = 3;
	localparam int IRQ_PULSE   = 2;
	localparam int TO_KICK     = 7;
	localparam int TO_LOCK     = 6;
	localparam int TRIM_OSCOFF = 7;
	localparam int TRIM_SIGN   = 5;
	localparam int ALM_MASK    = 7;

	// ****************************************************************
	// Reset values and writable masks
	// ****************************************************************
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] IRQ_RESET   = 8'h08;
	localparam logic [7:0] IRQ_WMASK   = 8'hec;
	localparam logic [7:0] TRIM_RESET  = 8'h00;
	localparam logic [7:0] TRIM_WMASK  = 8'hbf;
	localparam logic [7:0] ALM_RESET   = 8'h80;
	localparam logic [5:0] WD_RESET    = 6'h00;
	localparam logic [7:0] RD_NONE     = 8'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int          OSC_HZ        = 32768;
	localparam logic [16:0] SEC_NOM       = 17'(OSC_HZ);
	localparam logic [16:0] SEC_SHORT     = 17'(OSC_HZ - 128);
	localparam logic [16:0] SEC_LONG      = 17'(OSC_HZ + 256);
	localparam logic [5:0]  SECS_LAST     = 6'h3b;
	localparam logic [5:0]  TRIM_MIN_LAST = 6'h3e;
	localparam int          TEST_HZ       = 512;
	localparam logic [9:0]  TEST_HALF_M1  = 10'(OSC_HZ / (2 * TEST_HZ) - 1);
	localparam int          WD_TICK_US    = 31250;
	localparam logic [9:0]  WD_DIV_M1     = 10'(OSC_HZ * WD_TICK_US / 1_000_000 - 1);
	localparam int          MCLK_HZ       = 100_000_000;
	localparam int          PULSE_MS      = 200;
	localparam int          PULSE_DEF     = MCLK_HZ / 1000 * PULSE_MS;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [7:0] date;
		logic [7:0] hours;
		logic [7:0] minutes;
		logic [7:0] seconds;
	} time_type;

endpackage

// *** test/irq_host_model.sv ***
`timescale 1ns/1ps

// ********************************************************
// Interrupt line as the host sees it.
// ********************************************************
module irq_host_model (
	input  wire logic i_drive,
	input  wire logic i_oe,
	output logic      o_level
);
	// pull-up on release
	// A released open-drain line floats to the pull-up, so the host reads it high.
	assign o_level = i_oe ? i_drive : 1'b1;
endmodule

// *** test/rtc_trim_alarm_watchdog_irq_tb.sv ***
`timescale 1ns/1ps

module rtc_trim_alarm_watchdog_irq_tb;
	import rtc_trim_pkg::*;
	localparam int PULSE = 50;
	logic        i_mclk, i_rstn, i_osc_clk, i_vcc_low, i_on_backup, i_osc_fail;
	logic        i_sel, i_wr, i_rd, i_sec_update;
	logic [14:0] i_addr;
	logic [7:0]  i_wdata, o_rdata;
	time_type    i_now;
	logic        o_sec_tick, o_osc_disable, o_irq_out, o_irq_oe, pin;
	int          n_fail, n_checks, t, n_sec;

	rtc_trim_alarm_watchdog_irq #(.PULSE_CYCLES(PULSE)) DUT (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_osc_clk(i_osc_clk), .i_vcc_low(i_vcc_low),
		.i_on_backup(i_on_backup), .i_osc_fail(i_osc_fail), .i_sel(i_sel), .i_wr(i_wr),
		.i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .i_sec_update(i_sec_update),
		.i_now(i_now), .o_rdata(o_rdata), .o_sec_tick(o_sec_tick),
		.o_osc_disable(o_osc_disable), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe)
	);
	irq_host_model host (.i_drive(o_irq_out), .i_oe(o_irq_oe), .o_level(pin));

	initial begin
		i_mclk = 0;
		forever #5 i_mclk = ~i_mclk;
	end
	// The oscillator runs fast so that a watchdog tick takes about 4096 cycles.
	initial begin
		i_osc_clk = 0;
		forever #20 i_osc_clk = ~i_osc_clk;
	end

	// ********************************************************
	// Bus tasks
	// ********************************************************
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [14:0] a, input logic [7:0] d);
		@(posedge i_mclk) #1;
		i_sel = 1;
		i_wr = 1;
		i_addr = a;
		i_wdata = d;
		@(posedge i_mclk) #1;
		i_sel = 0;
		i_wr = 0;
	endtask
	task rdc(input string nm, input logic [14:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge i_mclk) #1;
		i_sel = 1;
		i_rd = 1;
		i_addr = a;
		@(posedge i_mclk) #1;
		i_sel = 0;
		i_rd = 0;
		chk(nm, e & m, o_rdata & m);
	endtask
	task cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task wait_pin(input logic v, input int lim, output int n);
		n = 0;
		while (pin !== v && n < lim) begin
			@(posedge i_mclk) #1;
			n++;
		end
	endtask
	task tick_sec(input logic [7:0] s);
		@(posedge i_mclk) #1;
		i_now.seconds = s;
		i_sec_update = 1;
		@(posedge i_mclk) #1;
		i_sec_update = 0;
		cyc(5);
	endtask
	task count_toggles(output int n);
		logic p;
		n = 0;
		p = pin;
		repeat (1280) begin
			@(posedge i_mclk) #1;
			if (pin !== p) n++;
			p = pin;
		end
	endtask
	// The run is far shorter than one second, so no trimmed second may end.
	always @(posedge i_mclk) begin
		if (o_sec_tick === 1'b1) n_sec++;
	end
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	initial begin
		#500_000;
		n_fail++;
		$display("BAD run time limit reached");
		tally_and_finish;
	end

	// ********************************************************
	// Tests
	// ********************************************************
	initial begin
		{i_rstn, i_vcc_low, i_on_backup, i_osc_fail, i_sel, i_wr, i_rd, i_sec_update} = '0;
		i_addr = '0;
		i_wdata = '0;
		i_now = '0;
		n_fail = 0;
		n_checks = 0;
		n_sec = 0;
		repeat (4) @(posedge i_mclk);
		#1 i_rstn = 1;
		rdc("flags", ADDR_FLAGS, 8'h00, 8'hff);
		rdc("irq ctl", ADDR_IRQ, 8'h08, 8'hff);
		rdc("trim", ADDR_TRIM, 8'h00, 8'hff);
		rdc("timeout", ADDR_TIMEOUT, 8'h00, 8'hff);
		rdc("unmapped", 15'h7ff1, 8'h00, 8'hff);
		for (int k = 0; k < 4; k++) rdc("alarm", ADDR_ALM_BASE + 15'(k), 8'h80, 8'hff);
		chk("pin idle", 8'h00, 8'(pin));
		chk("osc on", 8'h00, 8'(o_osc_disable));
		$display("test reset done");

		wr(ADDR_ALM_BASE + 15'h1, 8'h12);
		rdc("alarm unfrozen", ADDR_ALM_BASE + 15'h1, 8'h80, 8'hff);
		wr(ADDR_IRQ, 8'h48);
		wr(ADDR_FLAGS, 8'h02);
		wr(ADDR_ALM_BASE, 8'h30);
		tick_sec(8'h30);
		chk("alarm frozen", 8'h00, 8'(pin));
		wr(ADDR_FLAGS, 8'h00);
		tick_sec(8'h29);
		chk("alarm miss", 8'h00, 8'(pin));
		tick_sec(8'h30);
		chk("alarm hit", 8'h01, 8'(pin));
		rdc("flags alarm", ADDR_FLAGS, 8'h40, 8'hff);
		cyc(3);
		chk("level cleared", 8'h00, 8'(pin));
		$display("test alarm done");

		wr(ADDR_IRQ, 8'h88);
		wr(ADDR_TIMEOUT, 8'h02);
		wr(ADDR_TIMEOUT, 8'hc5);
		rdc("timeout locked", ADDR_TIMEOUT, 8'h02, 8'h3f);
		cyc(3900);
		chk("early timeout", 8'h00, 8'(pin));
		wr(ADDR_TIMEOUT, 8'hc0);
		wait_pin(1, 9000, t);
		chk("timeout span", 8'h01, 8'(t > 3900 && t < 9000));
		rdc("flags timeout", ADDR_FLAGS, 8'h80, 8'hff);
		wr(ADDR_TIMEOUT, 8'h82);
		wr(ADDR_TIMEOUT, 8'h00);
		cyc(9000);
		chk("timeout off", 8'h00, 8'(pin));
		$display("test watchdog done");

		wr(ADDR_IRQ, 8'h24);
		cyc(3);
		chk("open drain idle", 8'h01, 8'(pin));
		i_vcc_low = 1;
		wait_pin(0, 20, t);
		chk("supply irq", 8'h01, 8'(t < 20));
		wait_pin(1, 80, t);
		chk("pulse width", 8'h01, 8'(t >= PULSE - 5 && t <= PULSE + 5));
		rdc("flags supply", ADDR_FLAGS, 8'h20, 8'hff);
		i_vcc_low = 0;
		i_on_backup = 1;
		cyc(4);
		i_vcc_low = 1;
		wait_pin(0, 30, t);
		chk("backup quiet", 8'h1e, 8'(t));
		i_vcc_low = 0;
		wr(ADDR_IRQ, 8'h08);
		i_on_backup = 0;
		cyc(4);
		rdc("flags drain", ADDR_FLAGS, 8'h20, 8'hff);
		$display("test supply done");

		wr(ADDR_FLAGS, 8'h02);
		wr(ADDR_FLAGS, 8'h06);
		wr(ADDR_FLAGS, 8'h04);
		wr(ADDR_TRIM, 8'h3f);
		rdc("trim value", ADDR_TRIM, 8'h3f, 8'hff);
		count_toggles(t);
		chk("tone toggles", 8'h01, 8'(t >= 9 && t <= 11));
		i_vcc_low = 1;
		cyc(4);
		count_toggles(t);
		chk("tone under threshold", 8'h00, 8'(t));
		i_vcc_low = 0;
		wr(ADDR_TRIM, 8'hbf);
		chk("osc disable", 8'h01, 8'(o_osc_disable));
		cyc(3);
		count_toggles(t);
		chk("tone stopped", 8'h00, 8'(t));
		wr(ADDR_FLAGS, 8'h06);
		wr(ADDR_FLAGS, 8'h02);
		wr(ADDR_FLAGS, 8'h00);
		chk("sec ticks", 8'h00, 8'(n_sec));
		$display("test tone done");
		tally_and_finish;
	end
endmodule
